// *** verilog/irt_timer_top.sv ***
// infrared timer pair: narrow and wide counters, demodulation, ping-pong
// Notes on behaviour
// - initial count of one is illegal in either counter; software avoids it
// - wide count from zero wraps to FFFFH without a timeout flag
// - demodulation waits for first selected edge, captures, reloads, counts
// - with D6 clear, later edges capture the complemented count
// - each edge capture sets an edge flag; interrupt if capture enable set
// - after a later-edge capture the wide counter reloads FFFFH and counts on
// - with D6 set, edges after the first are ignored
// - with D6 set, narrow timeout captures complemented wide count, no reload, interrupt
// - writing D6 zero then one re-arms one capture-and-reload on next edge
// - demodulation zero reached: continue from FFFFH, set timeout, interrupt
// - enabling either counter starts ping-pong alternation
// - narrow start drives its initial level and loads high or low reload
// - narrow terminal count disables it, starts wide at its initial level
// - wide terminal count stops it and restarts narrow, forever
// - each terminal count interrupts when its own enable bit is set
// - writing 00 to ping-pong select ends ping-pong
// - every restart reloads the initial value
// - ping-pong hardware toggles enables and sets timeout flags
//
// The register addresses and the strobed register port were chosen for this implementation.
module irt_timer_top (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic IR_IN,
  output logic [7:0] RDATA_OUT,
  output logic NARROW_OUTPUT_OUT,
  output logic WIDE_OUTPUT_OUT,
  output logic NARROW_IRQ_OUT,
  output logic WIDE_IRQ_OUT
);
  typedef struct packed {
    logic [7:0] narrow_ctl;
    logic [7:0] shared_ctl;
    logic [7:0] wide_ctl;
    logic [7:0] narrow_reload_high;
    logic [7:0] narrow_reload_low;
    logic [7:0] wide_reload_high;
    logic [7:0] wide_reload_low;
    logic [7:0] capture_high;
    logic [7:0] capture_low;
    logic narrow_output;
    logic wide_output;
    logic narrow_en_q;
    logic wide_en_q;
    logic one_shot_q;
    irt_pkg::irt_demod_t dstate;
    logic [7:0] rdata;
    logic narrow_irq;
    logic wide_irq;
  } irt_state_t;

  irt_state_t s;
  irt_state_t next_s;

  logic [7:0] narrow_cnt;
  logic [15:0] wide_cnt;
  logic edge_rise;
  logic edge_fall;
  logic edge_hit;
  logic demod;
  logic pp;
  logic narrow_start;
  logic wide_start;
  logic narrow_run;
  logic wide_run;
  logic narrow_tc;
  logic wide_tc;
  logic first_hit;
  logic again_hit;
  logic mark_cap;
  logic any_cap;
  logic narrow_load;
  logic wide_load;
  logic [7:0] narrow_load_val;
  logic [15:0] wide_load_val;

  // counters and edge detector
  irt_down_counter #(.W(8)) u_narrow (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .load_in(narrow_load),
    .load_val_in(narrow_load_val),
    .run_in(narrow_run),
    .cnt_out(narrow_cnt)
  );

  irt_down_counter #(.W(16)) u_wide (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .load_in(wide_load),
    .load_val_in(wide_load_val),
    .run_in(wide_run),
    .cnt_out(wide_cnt)
  );

  irt_edge_detect u_edge (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .sig_in(IR_IN),
    .rise_sel_in(s.shared_ctl[irt_pkg::SH_EDGE_RISE]),
    .fall_sel_in(s.shared_ctl[irt_pkg::SH_EDGE_FALL]),
    .rise_out(edge_rise),
    .fall_out(edge_fall),
    .hit_out(edge_hit)
  );

  // mode decode and start detection
  assign demod = s.shared_ctl[irt_pkg::SH_RECEIVE];
  assign pp = ~demod &
              (s.shared_ctl[irt_pkg::SH_PP_HI:irt_pkg::SH_PP_LO] != irt_pkg::PP_OFF);
  assign narrow_start = s.narrow_ctl[irt_pkg::CTL_ENABLE] & ~s.narrow_en_q;
  assign wide_start = ~demod & s.wide_ctl[irt_pkg::CTL_ENABLE] & ~s.wide_en_q;
  assign narrow_run = s.narrow_ctl[irt_pkg::CTL_ENABLE] & ~narrow_start;
  assign wide_run = demod ? (s.dstate == irt_pkg::IRT_DM_COUNT)
                          : (s.wide_ctl[irt_pkg::CTL_ENABLE] & ~wide_start);
  // terminal count as the count steps onto zero; a load from zero wraps silently
  assign narrow_tc = narrow_run & (narrow_cnt == irt_pkg::NARROW_ONE);
  assign wide_tc = wide_run & (wide_cnt == irt_pkg::WIDE_ONE);

  // demodulation capture events
  assign first_hit = demod & s.wide_ctl[irt_pkg::CTL_ENABLE] &
                     (s.dstate == irt_pkg::IRT_DM_WAIT) & edge_hit;
  assign again_hit = demod & (s.dstate == irt_pkg::IRT_DM_COUNT) &
                     ~s.wide_ctl[irt_pkg::CTL_ONE_SHOT] & edge_hit;
  assign mark_cap = demod & (s.dstate == irt_pkg::IRT_DM_COUNT) &
                    s.wide_ctl[irt_pkg::CTL_ONE_SHOT] & narrow_tc;
  assign any_cap = first_hit | again_hit | mark_cap;

  // counter loads: restart, modulo reload, capture reload
  assign narrow_load = narrow_start |
                       (narrow_tc & ~s.narrow_ctl[irt_pkg::CTL_ONE_SHOT] & ~pp);
  assign narrow_load_val = narrow_start ?
    irt_pkg::irt_pick(s.shared_ctl[irt_pkg::SH_NARROW_INIT], s.narrow_reload_high,
                      s.narrow_reload_low) :
    irt_pkg::irt_pick(~s.narrow_output, s.narrow_reload_high,
                      s.narrow_reload_low);
  assign wide_load = wide_start | first_hit | again_hit |
                     (~demod & wide_tc & ~s.wide_ctl[irt_pkg::CTL_ONE_SHOT] & ~pp);
  assign wide_load_val = again_hit ? irt_pkg::WIDE_FULL
                                   : {s.wide_reload_high, s.wide_reload_low};

  // next state: software writes first, hardware events after so sets win
  always_comb begin
    next_s = s;
    next_s.rdata = irt_pkg::REG_RESET;
    next_s.narrow_irq = 1'b0;
    next_s.wide_irq = 1'b0;
    next_s.narrow_en_q = s.narrow_ctl[irt_pkg::CTL_ENABLE];
    next_s.wide_en_q = s.wide_ctl[irt_pkg::CTL_ENABLE];
    next_s.one_shot_q = s.wide_ctl[irt_pkg::CTL_ONE_SHOT];
    if (WR_IN) begin
      unique case (ADDR_IN)
        irt_pkg::ADDR_NARROW_CTL: begin
          next_s.narrow_ctl = WDATA_IN;
          next_s.narrow_ctl[irt_pkg::CTL_TIMEOUT] =
            s.narrow_ctl[irt_pkg::CTL_TIMEOUT] & ~WDATA_IN[irt_pkg::CTL_TIMEOUT];
        end
        irt_pkg::ADDR_SHARED_CTL: begin
          next_s.shared_ctl = WDATA_IN;
          if (WDATA_IN[irt_pkg::SH_RECEIVE]) begin
            next_s.shared_ctl[irt_pkg::SH_RISE_SEEN] =
              s.shared_ctl[irt_pkg::SH_RISE_SEEN] & ~WDATA_IN[irt_pkg::SH_RISE_SEEN];
            next_s.shared_ctl[irt_pkg::SH_FALL_SEEN] =
              s.shared_ctl[irt_pkg::SH_FALL_SEEN] & ~WDATA_IN[irt_pkg::SH_FALL_SEEN];
          end
        end
        irt_pkg::ADDR_WIDE_CTL: begin
          next_s.wide_ctl = WDATA_IN;
          next_s.wide_ctl[irt_pkg::CTL_TIMEOUT] =
            s.wide_ctl[irt_pkg::CTL_TIMEOUT] & ~WDATA_IN[irt_pkg::CTL_TIMEOUT];
        end
        irt_pkg::ADDR_NARROW_RLD_HIGH: next_s.narrow_reload_high = WDATA_IN;
        irt_pkg::ADDR_NARROW_RLD_LOW: next_s.narrow_reload_low = WDATA_IN;
        irt_pkg::ADDR_WIDE_RLD_HIGH: next_s.wide_reload_high = WDATA_IN;
        irt_pkg::ADDR_WIDE_RLD_LOW: next_s.wide_reload_low = WDATA_IN;
        default: ;
      endcase
    end
    // read data for the following cycle only
    if (RD_IN) begin
      unique case (ADDR_IN)
        irt_pkg::ADDR_NARROW_CTL: next_s.rdata = s.narrow_ctl;
        irt_pkg::ADDR_SHARED_CTL: next_s.rdata = s.shared_ctl;
        irt_pkg::ADDR_WIDE_CTL: next_s.rdata = s.wide_ctl;
        irt_pkg::ADDR_NARROW_RLD_HIGH: next_s.rdata = s.narrow_reload_high;
        irt_pkg::ADDR_NARROW_RLD_LOW: next_s.rdata = s.narrow_reload_low;
        irt_pkg::ADDR_WIDE_RLD_HIGH: next_s.rdata = s.wide_reload_high;
        irt_pkg::ADDR_WIDE_RLD_LOW: next_s.rdata = s.wide_reload_low;
        irt_pkg::ADDR_CAPTURE_HIGH: next_s.rdata = s.capture_high;
        irt_pkg::ADDR_CAPTURE_LOW: next_s.rdata = s.capture_low;
        default: next_s.rdata = irt_pkg::REG_RESET;
      endcase
    end
    // narrow counter output and terminal count
    if (narrow_start) begin
      next_s.narrow_output = s.shared_ctl[irt_pkg::SH_NARROW_INIT];
    end else if (narrow_tc) begin
      next_s.narrow_output = ~s.narrow_output;
    end
    if (narrow_tc) begin
      next_s.narrow_ctl[irt_pkg::CTL_TIMEOUT] = 1'b1;
      next_s.narrow_irq = s.narrow_ctl[irt_pkg::CTL_TOUT_IE];
      if (s.narrow_ctl[irt_pkg::CTL_ONE_SHOT] | pp) begin
        next_s.narrow_ctl[irt_pkg::CTL_ENABLE] = 1'b0;
      end
      if (pp) begin
        next_s.wide_ctl[irt_pkg::CTL_ENABLE] = 1'b1;
      end
    end
    // wide counter output and terminal count
    if (wide_start) begin
      next_s.wide_output = s.shared_ctl[irt_pkg::SH_WIDE_INIT];
    end else if (wide_tc & ~demod) begin
      next_s.wide_output = ~s.wide_output;
    end
    if (wide_tc) begin
      next_s.wide_ctl[irt_pkg::CTL_TIMEOUT] = 1'b1;
      next_s.wide_irq = s.wide_ctl[irt_pkg::CTL_TOUT_IE];
      if (~demod & (s.wide_ctl[irt_pkg::CTL_ONE_SHOT] | pp)) begin
        next_s.wide_ctl[irt_pkg::CTL_ENABLE] = 1'b0;
      end
      if (pp) begin
        next_s.narrow_ctl[irt_pkg::CTL_ENABLE] = 1'b1;
      end
    end
    // captures of the complemented wide count
    if (any_cap) begin
      {next_s.capture_high, next_s.capture_low} = ~wide_cnt;
      if (s.wide_ctl[irt_pkg::CTL_CAP_IE]) begin
        next_s.wide_irq = 1'b1;
      end
    end
    if (first_hit | again_hit) begin
      if (edge_rise) begin
        next_s.shared_ctl[irt_pkg::SH_RISE_SEEN] = 1'b1;
      end
      if (edge_fall) begin
        next_s.shared_ctl[irt_pkg::SH_FALL_SEEN] = 1'b1;
      end
    end
    // demodulation sequencing
    if (~demod | ~s.wide_ctl[irt_pkg::CTL_ENABLE]) begin
      next_s.dstate = irt_pkg::IRT_DM_IDLE;
    end else begin
      unique case (s.dstate)
        irt_pkg::IRT_DM_IDLE: next_s.dstate = irt_pkg::IRT_DM_WAIT;
        irt_pkg::IRT_DM_WAIT: begin
          if (first_hit) begin
            next_s.dstate = irt_pkg::IRT_DM_COUNT;
          end
        end
        irt_pkg::IRT_DM_COUNT: begin
          if (s.wide_ctl[irt_pkg::CTL_ONE_SHOT] & ~s.one_shot_q) begin
            next_s.dstate = irt_pkg::IRT_DM_WAIT;
          end
        end
        default: next_s.dstate = irt_pkg::IRT_DM_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign RDATA_OUT = s.rdata;
  assign NARROW_OUTPUT_OUT = s.narrow_output;
  assign WIDE_OUTPUT_OUT = s.wide_output;
  assign NARROW_IRQ_OUT = s.narrow_irq;
  assign WIDE_IRQ_OUT = s.wide_irq;

  // checks on the timer behaviour
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  a_timeout_cause: assert property (
    $rose(s.wide_ctl[irt_pkg::CTL_TIMEOUT]) |-> $past(wide_tc))
    else $error("wide timeout flag without terminal count");

  a_first_edge_load: assert property (
    first_hit |=> s.dstate == irt_pkg::IRT_DM_COUNT &&
      wide_cnt == {$past(s.wide_reload_high), $past(s.wide_reload_low)})
    else $error("first edge did not reload and start");

  a_space_capture: assert property (
    again_hit |=> {s.capture_high, s.capture_low} == ~$past(wide_cnt))
    else $error("space capture not complemented count");

  a_edge_flag_irq: assert property (
    (again_hit && s.wide_ctl[irt_pkg::CTL_CAP_IE]) |=> WIDE_IRQ_OUT &&
      (s.shared_ctl[irt_pkg::SH_RISE_SEEN] || s.shared_ctl[irt_pkg::SH_FALL_SEEN]))
    else $error("edge capture lacks flag or interrupt");

  a_space_reload: assert property (
    again_hit |=> wide_cnt == irt_pkg::WIDE_FULL)
    else $error("wide counter not reloaded with all ones");

  a_mark_ignores: assert property (
    (demod && s.dstate == irt_pkg::IRT_DM_COUNT && s.wide_ctl[irt_pkg::CTL_ONE_SHOT]
      && edge_hit && s.one_shot_q) |=> wide_cnt == $past(wide_cnt) - 16'h0001)
    else $error("mark mode reacted to an edge");

  a_mark_capture: assert property (
    mark_cap |=> {s.capture_high, s.capture_low} == ~$past(wide_cnt) &&
      wide_cnt == $past(wide_cnt) - 16'h0001)
    else $error("mark capture wrong or reloaded");

  a_demod_wrap: assert property (
    (demod && wide_tc) |=> ##1 wide_cnt == irt_pkg::WIDE_FULL &&
      s.wide_ctl[irt_pkg::CTL_TIMEOUT])
    else $error("demodulation wrap not flagged");

  a_pp_to_wide: assert property (
    (pp && narrow_tc) |=> !s.narrow_ctl[irt_pkg::CTL_ENABLE] &&
      s.wide_ctl[irt_pkg::CTL_ENABLE] ##1 WIDE_OUTPUT_OUT ==
      s.shared_ctl[irt_pkg::SH_WIDE_INIT])
    else $error("ping-pong hand-over to wide failed");

  a_pp_to_narrow: assert property (
    (pp && wide_tc) |=> s.narrow_ctl[irt_pkg::CTL_ENABLE] &&
      !s.wide_ctl[irt_pkg::CTL_ENABLE])
    else $error("ping-pong hand-over to narrow failed");

  a_restart_load: assert property (
    narrow_start |=> narrow_cnt == $past(narrow_load_val))
    else $error("narrow restart did not reload");
endmodule // irt_timer_top

// *** shared/irt_pkg.sv ***
// constants, register map and types of the infrared timer pair
package irt_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_NARROW_CTL = 4'h0;
  localparam logic [3:0] ADDR_SHARED_CTL = 4'h1;
  localparam logic [3:0] ADDR_WIDE_CTL = 4'h2;
  localparam logic [3:0] ADDR_NARROW_RLD_HIGH = 4'h3;
  localparam logic [3:0] ADDR_NARROW_RLD_LOW = 4'h4;
  localparam logic [3:0] ADDR_WIDE_RLD_HIGH = 4'h5;
  localparam logic [3:0] ADDR_WIDE_RLD_LOW = 4'h6;
  localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h7;
  localparam logic [3:0] ADDR_CAPTURE_LOW = 4'h8;
  // bits of the narrow and wide control registers
  localparam int unsigned CTL_ENABLE = 7;
  localparam int unsigned CTL_ONE_SHOT = 6;
  localparam int unsigned CTL_TIMEOUT = 5;
  localparam int unsigned CTL_CAP_IE = 2;
  localparam int unsigned CTL_TOUT_IE = 1;
  // bits of the shared control register
  localparam int unsigned SH_RECEIVE = 7;
  localparam int unsigned SH_EDGE_RISE = 5;
  localparam int unsigned SH_EDGE_FALL = 4;
  localparam int unsigned SH_PP_HI = 3;
  localparam int unsigned SH_PP_LO = 2;
  localparam int unsigned SH_NARROW_INIT = 1;
  localparam int unsigned SH_WIDE_INIT = 0;
  localparam int unsigned SH_RISE_SEEN = 1;
  localparam int unsigned SH_FALL_SEEN = 0;
  localparam logic [1:0] PP_OFF = 2'b00;
  // reset values and counter constants
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] NARROW_ONE = 8'h01;
  localparam logic [15:0] WIDE_ONE = 16'h0001;
  localparam logic [15:0] WIDE_FULL = 16'hFFFF;
  localparam logic [15:0] WIDE_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    IRT_DM_IDLE = 2'b00,
    IRT_DM_WAIT = 2'b01,
    IRT_DM_COUNT = 2'b11
  } irt_demod_t;

  // reload value chosen by the output level
  function automatic logic [7:0] irt_pick(input logic level, input logic [7:0] high,
                                          input logic [7:0] low);
    irt_pick = level ? high : low;
  endfunction
endpackage

// *** verilog/irt_down_counter.sv ***
// loadable down-counter used for both timers
module irt_down_counter #(
  parameter int unsigned W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [W-1:0] load_val_in,
  input wire logic run_in,
  output logic [W-1:0] cnt_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } irt_cnt_state_t;

  irt_cnt_state_t s;
  irt_cnt_state_t next_s;

  // load beats decrement; zero wraps to all ones
  always_comb begin
    next_s = s;
    if (load_in) begin
      next_s.cnt = load_val_in;
    end else if (run_in) begin
      next_s.cnt = s.cnt - W'(1);
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cnt_out = s.cnt;
endmodule // irt_down_counter

// *** verilog/irt_edge_detect.sv ***
// edge detector for the carrier input with edge select
module irt_edge_detect (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sig_in,
  input wire logic rise_sel_in,
  input wire logic fall_sel_in,
  output logic rise_out,
  output logic fall_out,
  output logic hit_out
);
  typedef struct packed {
    logic prev;
  } irt_edge_state_t;

  irt_edge_state_t s;
  irt_edge_state_t next_s;

  // remember last input level
  always_comb begin
    next_s = s;
    next_s.prev = sig_in;
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // raw edges, and the hit qualified per select bits
  assign rise_out = sig_in & ~s.prev;
  assign fall_out = ~sig_in & s.prev;
  assign hit_out = (rise_out & rise_sel_in) | (fall_out & fall_sel_in);
endmodule // irt_edge_detect

// *** bench/irt_carrier_src.sv ***
// carrier source model: single carrier marks on request
module irt_carrier_src (
  input wire logic clk_in,
  input wire logic pulse_in,
  input wire logic [7:0] mark_len_in,
  output logic ir_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hold;
  initial begin
    ir_out = 1'b0;
    hold = 8'h00;
  end
  // raise the line on request, drop it after the mark length
  always @(posedge clk_in) begin
    if (pulse_in) begin
      ir_out <= 1'b1;
      hold <= mark_len_in;
    end else if (hold != 8'h00) begin
      hold <= hold - 8'h01;
      if (hold == 8'h01) ir_out <= 1'b0; // idle level between marks
    end
  end
endmodule // irt_carrier_src

// *** bench/test_irt_timer_top.sv ***
// self-checking bench of the infrared timer pair
module test_irt_timer_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd, pulse, ir, n_out, w_out, n_irq, w_irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, got, mlen;
  logic [15:0] cap1, cap2;
  int failures, total_checks, cyc, tp, n;

  irt_timer_top irt_timer_top_i (.CLK_SYS_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .IR_IN(ir), .RDATA_OUT(rdata),
    .NARROW_OUTPUT_OUT(n_out), .WIDE_OUTPUT_OUT(w_out), .NARROW_IRQ_OUT(n_irq),
    .WIDE_IRQ_OUT(w_irq));
  irt_carrier_src irt_carrier_src_i (.clk_in(clk), .pulse_in(pulse), .mark_len_in(mlen),
    .ir_out(ir));

  // clock and cycle count
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial cyc = 0;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask

  task automatic read_cap(output logic [15:0] v);
    reg_rd(irt_pkg::ADDR_CAPTURE_HIGH);
    v[15:8] = got;
    reg_rd(irt_pkg::ADDR_CAPTURE_LOW);
    v[7:0] = got;
  endtask

  // bounded wait for an interrupt pulse; n holds the cycles waited
  task automatic wait_irq(input logic wide, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (((wide ? w_irq : n_irq) !== 1'b1) && n < lim);
  endtask

  task automatic expect_irq(input string what, input logic wide, input int lim,
                            input logic want);
    wait_irq(wide, lim);
    check(what, {15'h0000, n < lim}, {15'h0000, want});
  endtask

  task automatic send_mark();
    @(posedge clk);
    pulse <= 1'b1;
    tp = cyc;
    @(posedge clk);
    pulse <= 1'b0;
  endtask

  // watchdog against a hang
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    pulse = 1'b0;
    mlen = 8'h04;
    failures = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped index ignoring writes and reading zero
    for (int a = 0; a < 9; a++) begin
      reg_rd(4'(a));
      check("reset value", {8'h00, got}, {8'h00, irt_pkg::REG_RESET});
    end
    reg_wr(4'h9, 8'h5A);
    reg_rd(4'h9);
    check("unmapped read", {8'h00, got}, 16'h0000);
    // ping-pong: narrow starts at level 1, wide at level 1
    reg_wr(irt_pkg::ADDR_NARROW_RLD_HIGH, 8'h10);
    reg_wr(irt_pkg::ADDR_NARROW_RLD_LOW, 8'h03);
    reg_wr(irt_pkg::ADDR_WIDE_RLD_HIGH, 8'h00);
    reg_wr(irt_pkg::ADDR_WIDE_RLD_LOW, 8'h30);
    reg_wr(irt_pkg::ADDR_NARROW_CTL, 8'h42);
    reg_wr(irt_pkg::ADDR_WIDE_CTL, 8'h42);
    reg_wr(irt_pkg::ADDR_SHARED_CTL, 8'h07);
    reg_wr(irt_pkg::ADDR_NARROW_CTL, 8'hC2);
    @(posedge clk);
    #1;
    check("narrow start level", {15'h0000, n_out}, 16'h0001);
    wait_irq(1'b0, 40);
    check("narrow period", 16'(n), 16'h0010);
    repeat (3) @(posedge clk);
    #1;
    check("wide start level", {15'h0000, w_out}, 16'h0001);
    reg_rd(irt_pkg::ADDR_NARROW_CTL);
    check("narrow ctl after tc", {8'h00, got}, 16'h0062);
    // read data must drop back to zero one cycle later
    @(posedge clk);
    #1;
    check("read data after", {8'h00, rdata}, 16'h0000);
    reg_rd(irt_pkg::ADDR_WIDE_CTL);
    check("wide ctl running", {8'h00, got}, 16'h00C2);
    expect_irq("wide tc irq", 1'b1, 80, 1'b1);
    reg_wr(irt_pkg::ADDR_SHARED_CTL, 8'h03);
    expect_irq("narrow again", 1'b0, 40, 1'b1);
    expect_irq("no wide after stop", 1'b1, 100, 1'b0);
    reg_rd(irt_pkg::ADDR_WIDE_CTL);
    check("wide ctl stopped", {8'h00, got}, 16'h0062);
    reg_wr(irt_pkg::ADDR_NARROW_CTL, 8'h20);
    reg_wr(irt_pkg::ADDR_WIDE_CTL, 8'h20);
    // demodulation, space mode on rising edges
    reg_wr(irt_pkg::ADDR_WIDE_RLD_HIGH, 8'hFF);
    reg_wr(irt_pkg::ADDR_WIDE_RLD_LOW, 8'hFF);
    reg_wr(irt_pkg::ADDR_SHARED_CTL, 8'hA3); // clears stale level bits as flags
    reg_wr(irt_pkg::ADDR_WIDE_CTL, 8'h84);
    repeat (5) @(posedge clk);
    send_mark();
    expect_irq("first capture", 1'b1, 10, 1'b1);
    reg_rd(irt_pkg::ADDR_SHARED_CTL);
    check("rise flag", {8'h00, got}, 16'h00A2);
    while (cyc < tp + 40) @(posedge clk);
    send_mark();
    expect_irq("space capture", 1'b1, 10, 1'b1);
    read_cap(cap1);
    check("capture high", {8'h00, cap1[15:8]}, 16'h0000);
    while (cyc < tp + 70) @(posedge clk);
    mlen <= 8'h20;
    send_mark();
    expect_irq("space capture", 1'b1, 10, 1'b1);
    read_cap(cap2);
    check("space difference", cap2 - cap1, 16'h001E);
    // long mark must end first, or the re-armed edge never comes
    while (ir) @(posedge clk);
    // mark mode: re-arm, one capture, later edges ignored, then wrap
    reg_wr(irt_pkg::ADDR_WIDE_CTL, 8'hC6);
    send_mark();
    cap1 = 16'(tp);
    expect_irq("re-armed capture", 1'b1, 10, 1'b1);
    repeat (40) @(posedge clk);
    send_mark();
    expect_irq("ignored edge", 1'b1, 30, 1'b0);
    wait_irq(1'b1, 70000);
    n = cyc - int'(cap1);
    check("wrap time", {15'h0000, n >= 65530 && n <= 65560}, 16'h0001);
    reg_rd(irt_pkg::ADDR_WIDE_CTL);
    check("wide timeout flag", {8'h00, got}, 16'h00E6);
    // narrow timeout captures without reload
    reg_wr(irt_pkg::ADDR_NARROW_RLD_LOW, 8'h40);
    reg_wr(irt_pkg::ADDR_NARROW_CTL, 8'h80);
    expect_irq("narrow tout capture", 1'b1, 80, 1'b1);
    read_cap(cap1);
    expect_irq("narrow tout capture", 1'b1, 80, 1'b1);
    read_cap(cap2);
    check("no reload between", cap2 - cap1, 16'h0040);
    stop_test();
  end
endmodule // test_irt_timer_top
